//--- bench/bopm_core_bench.sv
// Self-checking bench for the byte-op / move / pointer-load decoder
`timescale 1ns/100ps
module bopm_core_bench;
    import bopm_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] got;
    logic ack;
    logic iv = 1'b0;
    logic [15:0] iw = 16'h0;
    logic ready;
    bopm_mem_req_t req;
    logic [7:0] rdata;
    logic [7:0] accum;
    logic fn;
    logic fz;
    logic [31:0] seed = 32'h9;
    logic pre_we = 1'b0;
    logic [11:0] pre_addr = 12'h000;
    logic [7:0] pre_data = 8'h00;
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    int acc = 0;
    int n = 0;
    int z = 0;
    int ext = 0;
    int bank = 0;
    int ptr [3] = '{0, 0, 0};
    int em [4096];

    bopm_core #(.WB_ADR_W(8)) dut (.i_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_instr_valid(iv), .i_instr(iw), .o_instr_ready(ready),
        .o_mem_req(req), .i_mem_rdata(rdata), .o_accum(accum), .o_flag_n(fn), .o_flag_z(fz));
    bopm_mem_model mm (.i_clk(clk), .i_mem_req(req), .i_pre_we(pre_we), .i_pre_addr(pre_addr),
        .i_pre_data(pre_data), .o_mem_rdata(rdata));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Classic single cycle; ack looked at mid-cycle where it has settled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(negedge clk); while (ack !== 1'b1);
        got = rdat;
        @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input int e, input string nm);
        wb(1'b0, a, 32'h0);
        cmp(nm, e, got);
    endtask

    // Valid is left high; the caller lowers it, so back-to-back words need no gap
    task automatic instr(input logic [15:0] w);
        iv <= 1'b1;
        iw <= w;
        do @(negedge clk); while (ready !== 1'b1);
        @(posedge clk);
    endtask

    task automatic pload(input logic [1:0] s, input logic [11:0] k);
        instr({OPC_PTR1_PFX, 4'h0, s, k[11:8]});
        instr({OPC_PTR2_PFX, k[7:0]});
        iv <= 1'b0;
        @(posedge clk);
        if (s < 3) ptr[s] = k;
        for (int i = 0; i < 3; i++) rd(REG_PTR0 + 8'(4 * i), ptr[i], "pointer");
        rd(REG_STATUS, n * 2 + z, "status");
    endtask

    task automatic byte_op(input int op, input int d, input int a, input int f);
        int ad;
        int r;
        instr({op ? OPC_MOV_PFX : OPC_OR_PFX, 1'(d), 1'(a), 8'(f)});
        iv <= 1'b0;
        if (a) ad = bank * 256 + f;
        else if (ext && f <= 95) ad = (ptr[2] + f) % 4096;
        else if (f >= 96) ad = 'hF00 + f;
        else ad = f;
        r = em[ad] | (op ? 0 : acc);
        if (d) em[ad] = r;
        else acc = r;
        n = r >> 7;
        z = (r == 0);
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp("accum", acc, accum);
        cmp("flag_n", n, fn);
        cmp("flag_z", z, fz);
        cmp("memory", em[ad], mm.mem[ad]);
        @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4096; i++) begin
            em[i] = rnd() & 255;
            pre_we <= 1'b1;
            pre_addr <= 12'(i);
            pre_data <= 8'(em[i]);
            @(posedge clk);
        end
        pre_we <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) rd(8'(4 * i), 0, "reset value");
        $display("test reset done");
        for (int s = 0; s < 4; s++) pload(2'(s), 12'(rnd()));
        $display("test pointer load done");
        // Foreign second word is swallowed, unknown word ignored
        instr({OPC_PTR1_PFX, 4'h0, 2'h1, 4'hA});
        instr({OPC_OR_PFX, 2'h0, 8'h00});
        instr(16'h0000);
        iv <= 1'b0;
        @(posedge clk);
        ptr[1] = (ptr[1] & 255) + 'hA00;
        for (int i = 0; i < 3; i++) rd(REG_PTR0 + 8'(4 * i), ptr[i], "pointer");
        rd(REG_ACCUM, acc, "accum");
        rd(REG_STATUS, n * 2 + z, "status");
        $display("test refused words done");
        for (int i = 0; i < 300; i++) begin
            int f;
            if (i % 20 == 0) begin
                ext = rnd() & 1;
                bank = rnd() & 15;
                wb(1'b1, REG_CTRL, ext);
                wb(1'b1, REG_BANK, bank);
                rd(REG_BANK, bank, "bank");
                pload(2'h2, 12'(rnd()));
            end
            if (i % 7 == 0) begin
                acc = rnd() & 255;
                wb(1'b1, REG_ACCUM, acc);
            end
            f = (i % 5 == 1) ? 95 + (i / 5) % 2 : rnd() & 255;
            byte_op(i % 2, (rnd() >> 3) & 1, (rnd() >> 5) & 1, f);
        end
        rd(REG_STATUS, n * 2 + z, "status");
        $display("test byte ops done");
        test_done();
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end
endmodule

//--- bench/bopm_mem_model.sv
// Data memory partner model for the decoder's memory request port
`timescale 1ns/100ps
module bopm_mem_model (
    input wire logic i_clk,
    input wire bopm_pkg::bopm_mem_req_t i_mem_req,
    input wire logic i_pre_we,
    input wire logic [11:0] i_pre_addr,
    input wire logic [7:0] i_pre_data,
    output logic [7:0] o_mem_rdata
);
    import bopm_pkg::*;
    logic [7:0] mem [0:4095];
    logic [7:0] last_q = 8'h00;
    // ------------------------------------------------------------
    // Read and write ports
    // ------------------------------------------------------------
    // Outside a read the bus shows a changing pattern, the inverse of its value in the last cycle
    always_comb begin
        o_mem_rdata = i_mem_req.rd ? mem[i_mem_req.addr] : ~last_q;
    end
    always_ff @(posedge i_clk) begin
        last_q <= o_mem_rdata;
        // Preload keeps the array single-writer; it runs before any instruction
        if (i_pre_we) begin
            mem[i_pre_addr] <= i_pre_data;
        end else if (i_mem_req.we) begin
            mem[i_mem_req.addr] <= i_mem_req.wdata;
        end
    end
endmodule

//--- hw/bopm_core.sv
// Decode and execute of OR-with-file, move-file and pointer-load instructions
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module bopm_core #(
    parameter int WB_ADR_W = 8
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [WB_ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    output logic o_instr_ready,
    output bopm_pkg::bopm_mem_req_t o_mem_req,
    input wire logic [7:0] i_mem_rdata,
    output logic [7:0] o_accum,
    output logic o_flag_n,
    output logic o_flag_z
);
    import bopm_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bopm_state_t st_q, st_d;
    bopm_op_t op_q, op_d;
    logic dst_q, dst_d;
    logic [1:0] sel_q, sel_d;
    logic [7:0] w_q, w_d;
    logic n_q, n_d, z_q, z_d;
    logic [11:0] ptr_q [3];
    logic [11:0] ptr_d [3];
    bopm_mem_req_t mem_q, mem_d;
    logic ext_q, ext_d;
    logic [3:0] bank_q, bank_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;

    logic accept, wb_req, wb_wr, is_or, is_mov, is_ptr1, is_ptr2;
    logic [7:0] result;
    logic [7:0] adr8;

    assign o_instr_ready = (st_q == ST_IDLE) || (st_q == ST_PTR2);
    assign accept = i_instr_valid && o_instr_ready;
    assign is_or = i_instr[15:10] == OPC_OR_PFX; // RULE1
    assign is_mov = i_instr[15:10] == OPC_MOV_PFX; // RULE5
    assign is_ptr1 = i_instr[15:10] == OPC_PTR1_PFX; // RULE3
    assign is_ptr2 = i_instr[15:8] == OPC_PTR2_PFX; // RULE3
    assign result = (op_q == OP_OR) ? (w_q | i_mem_rdata) : i_mem_rdata; // RULE1 RULE5
    assign wb_req = i_wb_cyc && i_wb_stb;
    // Writes land on the edge where ack is seen high
    assign wb_wr = wb_req && i_wb_we && ack_q && i_wb_sel[0];
    assign adr8 = 8'(i_wb_adr);

    // ------------------------------------------------------------
    // Instruction sequencing
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        dst_d = dst_q;
        sel_d = sel_q;
        n_d = n_q;
        z_d = z_q;
        ptr_d = ptr_q;
        mem_d = '0;
        w_d = w_q;
        // Software write loses to a concurrent instruction result
        if (wb_wr && adr8 == REG_ACCUM) begin
            w_d = i_wb_dat[7:0];
        end
        case (st_q)
            ST_IDLE: begin
                if (accept && (is_or || is_mov)) begin
                    op_d = is_or ? OP_OR : OP_MOV;
                    dst_d = i_instr[9];
                    mem_d.rd = 1'b1;
                    mem_d.addr = byte_addr(i_instr[7:0], i_instr[8], ext_q, bank_q, ptr_q[2]);
                    st_d = ST_EXEC;
                end else if (accept && is_ptr1) begin
                    sel_d = i_instr[5:4];
                    if (i_instr[5:4] <= PTR_SEL_MAX) begin
                        ptr_d[i_instr[5:4]][11:8] = i_instr[3:0]; // RULE4
                    end
                    st_d = ST_PTR2;
                end
            end
            ST_EXEC: begin
                n_d = result[7]; // RULE1 RULE5
                z_d = result == 8'h00; // RULE1 RULE5
                if (dst_q) begin
                    mem_d.we = 1'b1; // RULE6
                    mem_d.addr = mem_q.addr;
                    mem_d.wdata = result;
                end else begin
                    w_d = result; // RULE6
                end
                st_d = ST_IDLE;
            end
            ST_PTR2: begin
                // A foreign second word is swallowed; flags never move here
                if (accept) begin
                    if (is_ptr2 && sel_q <= PTR_SEL_MAX) begin
                        ptr_d[sel_q][7:0] = i_instr[7:0]; // RULE4 RULE3
                    end
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= ST_IDLE;
            op_q <= OP_NONE;
            dst_q <= 1'b0;
            sel_q <= 2'h0;
            w_q <= ACCUM_RST;
            n_q <= 1'b0;
            z_q <= 1'b0;
            mem_q <= '0;
            for (int i = 0; i < 3; i++) begin
                ptr_q[i] <= PTR_RST;
            end
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            dst_q <= dst_d;
            sel_q <= sel_d;
            w_q <= w_d;
            n_q <= n_d;
            z_q <= z_d;
            mem_q <= mem_d;
            ptr_q <= ptr_d;
        end
    end

    // ------------------------------------------------------------
    // Wishbone register slave
    // ------------------------------------------------------------
    always_comb begin
        ack_d = wb_req && !ack_q;
        rdat_d = 32'h0000_0000;
        ext_d = ext_q;
        bank_d = bank_q;
        if (wb_req && !ack_q) begin
            case (adr8)
                REG_CTRL: rdat_d[CTRL_EXT_BIT] = ext_q;
                REG_BANK: rdat_d[3:0] = bank_q;
                REG_ACCUM: rdat_d[7:0] = w_q;
                REG_STATUS: begin
                    rdat_d[STAT_Z_BIT] = z_q;
                    rdat_d[STAT_N_BIT] = n_q;
                end
                REG_PTR0: rdat_d[11:0] = ptr_q[0];
                REG_PTR1: rdat_d[11:0] = ptr_q[1];
                REG_PTR2: rdat_d[11:0] = ptr_q[2];
                default: rdat_d = 32'h0000_0000;
            endcase
        end
        if (wb_wr && adr8 == REG_CTRL) begin
            ext_d = i_wb_dat[CTRL_EXT_BIT];
        end
        if (wb_wr && adr8 == REG_BANK) begin
            bank_d = i_wb_dat[3:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            ext_q <= CTRL_EXT_RST;
            bank_q <= BANK_RST;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            ext_q <= ext_d;
            bank_q <= bank_d;
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    assign o_mem_req = mem_q;
    assign o_accum = w_q;
    assign o_flag_n = n_q;
    assign o_flag_z = z_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic acc_byte, acc_ptr1, acc_ptr2;
    logic [11:0] ptr_sel_val;
    assign acc_byte = accept && st_q == ST_IDLE && (is_or || is_mov);
    assign acc_ptr1 = accept && st_q == ST_IDLE && is_ptr1 && !is_or && !is_mov;
    assign acc_ptr2 = accept && st_q == ST_PTR2 && is_ptr2;
    assign ptr_sel_val = (sel_q <= PTR_SEL_MAX) ? ptr_q[sel_q] : 12'h000;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence seq_byte_issue;
        acc_byte ##1 (st_q == ST_EXEC && o_mem_req.rd);
    endsequence
    sequence seq_ptr_first;
        acc_ptr1 ##1 (st_q == ST_PTR2);
    endsequence

    chk_byte_one_cycle: assert property (seq_byte_issue |=> st_q == ST_IDLE) // RULE1
        else $error("byte op did not finish after one execute cycle");
    chk_bank_addr: assert property (acc_byte && i_instr[8]
        |=> o_mem_req.addr == {$past(bank_q), $past(i_instr[7:0])}) // RULE8
        else $error("banked address wrong");
    chk_indexed_addr: assert property (acc_byte && !i_instr[8] && ext_q
        && i_instr[7:0] <= IDX_LIMIT
        |=> o_mem_req.addr == 12'($past(ptr_q[2]) + {4'h0, $past(i_instr[7:0])})) // RULE2
        else $error("indexed offset address wrong");
    chk_access_addr: assert property (acc_byte && !i_instr[8]
        && !(ext_q && i_instr[7:0] <= IDX_LIMIT)
        |=> o_mem_req.addr[7:0] == $past(i_instr[7:0]) && o_mem_req.addr[11:8]
        == ($past(i_instr[7:0]) >= ACCESS_SPLIT ? ACCESS_HI_BANK : ACCESS_LO_BANK)) // RULE8
        else $error("access bank address wrong");
    chk_or_accum: assert property (st_q == ST_EXEC && op_q == OP_OR && !dst_q
        |=> w_q == ($past(w_q) | $past(i_mem_rdata)) && z_q == (w_q == 8'h00)
        && n_q == w_q[7]) // RULE1
        else $error("OR result or flags wrong");
    chk_move_file: assert property (st_q == ST_EXEC && op_q == OP_MOV && dst_q
        |=> o_mem_req.we && o_mem_req.wdata == $past(i_mem_rdata)
        && n_q == $past(i_mem_rdata[7]) && z_q == ($past(i_mem_rdata) == 8'h00)) // RULE5
        else $error("move write-back or flags wrong");
    chk_dest_sel: assert property (st_q == ST_EXEC && !dst_q |=> !o_mem_req.we) // RULE6
        else $error("accumulator destination wrote memory");
    chk_ptr_flags: assert property (seq_ptr_first |-> $stable(n_q) && $stable(z_q)) // RULE3
        else $error("pointer load touched flags");
    chk_ptr_high: assert property (acc_ptr1 && i_instr[5:4] <= PTR_SEL_MAX
        |=> ptr_sel_val[11:8] == $past(i_instr[3:0])) // RULE4
        else $error("pointer high part not loaded");
    chk_ptr_low: assert property (acc_ptr2 && sel_q <= PTR_SEL_MAX
        |=> ptr_sel_val[7:0] == $past(i_instr[7:0]) && $stable(z_q)) // RULE4
        else $error("pointer low byte not loaded");
endmodule

//--- hw/bopm_pkg.sv
// Shared constants and types for the byte-op / move / pointer-load decoder
// Contract
// RULE1 - 000100da ffffffff ORs accumulator, sets N Z
// RULE2 - a=0, extended, f<=5Fh uses pointer-two offset
// RULE3 - Pointer load: two words, flags untouched
// RULE4 - Literal high nibble then low byte into pointer
// RULE5 - 010100da ffffffff moves file, sets N Z
// RULE6 - d=0 to accumulator, d=1 back to file
// RULE7 - File field spans whole 256-byte bank
// RULE8 - a=0 access bank, a=1 bank select
package bopm_pkg;
    // ------------------------------------------------------------
    // Opcode prefixes
    // ------------------------------------------------------------
    localparam logic [5:0] OPC_OR_PFX = 6'h04;
    localparam logic [5:0] OPC_MOV_PFX = 6'h14;
    localparam logic [5:0] OPC_PTR1_PFX = 6'h38;
    localparam logic [7:0] OPC_PTR2_PFX = 8'hF0;
    localparam logic [1:0] PTR_SEL_MAX = 2'h2;

    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BANK = 8'h04;
    localparam logic [7:0] REG_ACCUM = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_PTR0 = 8'h10;
    localparam logic [7:0] REG_PTR1 = 8'h14;
    localparam logic [7:0] REG_PTR2 = 8'h18;
    localparam int CTRL_EXT_BIT = 0;
    localparam int STAT_Z_BIT = 0;
    localparam int STAT_N_BIT = 1;
    localparam logic CTRL_EXT_RST = 1'b0;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [11:0] PTR_RST = 12'h000;

    typedef enum logic [1:0] {OP_NONE, OP_OR, OP_MOV} bopm_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_PTR2} bopm_state_t;

    typedef struct packed {
        logic rd;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } bopm_mem_req_t;

    // Effective data address of a byte-oriented access
    function automatic logic [11:0] byte_addr(input logic [7:0] f, input logic a,
                                              input logic ext, input logic [3:0] bank,
                                              input logic [11:0] ptr2);
        if (a) begin
            byte_addr = {bank, f}; // RULE8 RULE7
        end else if (ext && f <= IDX_LIMIT) begin
            byte_addr = 12'(ptr2 + {4'h0, f}); // RULE2
        end else if (f >= ACCESS_SPLIT) begin
            byte_addr = {ACCESS_HI_BANK, f}; // RULE8
        end else begin
            byte_addr = {ACCESS_LO_BANK, f}; // RULE8
        end
    endfunction
endpackage
